// ===== core/dmd_defines.vh
`ifndef DMD_DEFINES_VH
`define DMD_DEFINES_VH

// ****************************************************************
// register map, byte addresses on the apb bus
// ****************************************************************
`define DMD_ADDR_W          8
`define DMD_OFF_CONFIG      8'h00
`define DMD_OFF_SNAPSHOT    8'h04
`define DMD_OFF_DATA0       8'h08
`define DMD_OFF_DATA1       8'h0c
`define DMD_OFF_STATUS      8'h10

// ****************************************************************
// configuration register fields
// ****************************************************************
`define DMD_CFG_W           10
`define DMD_CFG_RESET       10'h050
`define DMD_CFG_STREAM_LSB  0
`define DMD_CFG_SHDN_LSB    2
`define DMD_CFG_RATIO_LSB   4
`define DMD_CFG_WIDE_BIT    6
`define DMD_CFG_LAT_BIT     7
`define DMD_CFG_BIAS_LSB    8

// ****************************************************************
// status register fields
// ****************************************************************
`define DMD_STS_READY_LSB   0
`define DMD_STS_SETTLED_LSB 2

// ****************************************************************
// quantizer thermometer codes
// ****************************************************************
`define DMD_CODE_P2         4'hf
`define DMD_CODE_P1         4'h7
`define DMD_CODE_ZERO       4'h3
`define DMD_CODE_M1         4'h1
`define DMD_CODE_M2         4'h0

// ****************************************************************
// decimation ratio select and limits
// ****************************************************************
`define DMD_RATIO_32        2'b00
`define DMD_RATIO_64        2'b01
`define DMD_RATIO_128       2'b10
`define DMD_RATIO_256       2'b11
`define DMD_LAST_32         8'h1f
`define DMD_LAST_64         8'h3f
`define DMD_LAST_128        8'h7f
`define DMD_LAST_256        8'hff
`define DMD_SETTLE_WORDS    2'd3
`define DMD_ROUND_HALF      25'h0000080
`define DMD_MAX24           24'h7fffff
`define DMD_MIN24           24'h800000
`define DMD_MAX16           16'h7fff
`define DMD_MIN16           16'h8000

`endif

// ===== core/dmd_sinc3.v
`timescale 1ns/1ps
`include "dmd_defines.vh"

module dmd_sinc3 (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire        clear,
    input  wire        sample_tick,
    input  wire [3:0]  code,
    input  wire [1:0]  ratio,
    input  wire        wide,
    output reg  [23:0] word_q,
    output reg         valid_q,
    output reg         settled_q
);

    // ****************************************************************
    // quantizer level and decimation length
    // ****************************************************************
    reg  signed [26:0] level;
    reg         [7:0]  last;
    reg  signed [26:0] int1_q;
    reg  signed [26:0] int2_q;
    reg  signed [26:0] int3_q;
    reg  signed [26:0] dly1_q;
    reg  signed [26:0] dly2_q;
    reg  signed [26:0] dly3_q;
    reg         [7:0]  dec_q;
    reg         [1:0]  settle_q;

    // thermometer code to signed level, illegal codes count as zero
    always @* begin
        case (code)
            `DMD_CODE_P2: level = 27'sd2;
            `DMD_CODE_P1: level = 27'sd1;
            `DMD_CODE_M1: level = -27'sd1;
            `DMD_CODE_M2: level = -27'sd2;
            default:      level = 27'sd0;
        endcase
    end

    // one shared ratio drives the decimation length
    always @* begin
        case (ratio)
            `DMD_RATIO_32:  last = `DMD_LAST_32;
            `DMD_RATIO_64:  last = `DMD_LAST_64;
            `DMD_RATIO_128: last = `DMD_LAST_128;
            default:        last = `DMD_LAST_256;
        endcase
    end

    // ****************************************************************
    // comb section and output formatting
    // ****************************************************************
    wire signed [26:0] comb1 = int3_q - dly1_q;
    wire signed [26:0] comb2 = comb1 - dly2_q;
    wire signed [26:0] comb3 = comb2 - dly3_q;
    wire signed [27:0] comb_x = {comb3[26], comb3};
    reg  signed [27:0] scaled;
    reg         [23:0] v24;
    wire        [24:0] sum25 = {v24[23], v24} + `DMD_ROUND_HALF;
    reg         [15:0] v16;

    // full scale of +-2 maps to +-2^23, so low bits fall to zero below ratio 256
    always @* begin
        case (ratio)
            `DMD_RATIO_32:  scaled = comb_x <<< 7;
            `DMD_RATIO_64:  scaled = comb_x <<< 4;
            `DMD_RATIO_128: scaled = comb_x <<< 1;
            default:        scaled = comb_x >>> 2;
        endcase
        if (!scaled[27] && (|scaled[26:23])) begin
            v24 = `DMD_MAX24;
        end else if (scaled[27] && !(&scaled[26:23])) begin
            v24 = `DMD_MIN24;
        end else begin
            v24 = scaled[23:0];
        end
        // round half up, clip instead of wrapping past the top code
        if (!v24[23] && sum25[23]) begin
            v16 = `DMD_MAX16;
        end else begin
            v16 = sum25[23:8];
        end
    end

    // ****************************************************************
    // integrators at sample rate, combs at output rate
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (reset || clear) begin
            int1_q    <= 27'sd0;
            int2_q    <= 27'sd0;
            int3_q    <= 27'sd0;
            dly1_q    <= 27'sd0;
            dly2_q    <= 27'sd0;
            dly3_q    <= 27'sd0;
            dec_q     <= 8'h00;
            settle_q  <= 2'd0;
            settled_q <= 1'b0;
            word_q    <= 24'h000000;
            valid_q   <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            if (sample_tick) begin
                // wraparound arithmetic is exact for the final difference
                int1_q <= int1_q + level;
                int2_q <= int2_q + int1_q;
                int3_q <= int3_q + int2_q;
                if (dec_q >= last) begin
                    dec_q   <= 8'h00;
                    dly1_q  <= int3_q;
                    dly2_q  <= comb1;
                    dly3_q  <= comb2;
                    valid_q <= 1'b1;
                    // two's complement, left justified in its word
                    word_q  <= wide ? v24 : {8'h00, v16};
                    if (settle_q != `DMD_SETTLE_WORDS) begin
                        settle_q <= settle_q + 2'd1;
                    end
                    // the third word after a restart is the first one flagged settled
                    settled_q <= (settle_q >= `DMD_SETTLE_WORDS - 2'd1);
                end else begin
                    dec_q <= dec_q + 8'h01;
                end
            end
        end
    end

endmodule

// ===== core/dmd_top.v
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "dmd_defines.vh"

// Operation
// - stream enable bit drives the channel pin as soon as written
// - four-bit thermometer result captured into snapshot each sample period
// - codes 1111,0111,0011,0001,0000 mean +2,+1,0,-1,-2
// - four quantizer bits leave serially, one per master clock
// - after reset or shutdown pins realign; first pattern is 0011
// - each channel runs a third-order sinc decimator at sample rate
// - decimator words are 16 or 24 bits by the width bit
// - filter counts as settled after three periods following restart
// - ratio field picks 32, 64, 128 or 256 decimation
// - 24-bit words are left justified with zero low bits below ratio 256
// - 16-bit words are rounded to nearest, not truncated
// - words are signed two's complement, msb justified
// - positive overrange clamps to 7fffff or 7fff
// - negative overrange clamps to 800000 or 8000
// - a shut down channel with stream on repeats 0011, or holds 0 when both are down
// - hard reset floats both pins and clears filters and buffers
// - both channels share one ratio setting

module dmd_top (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire        hard_reset_n,
    input  wire        analog_master_clock_tick,
    input  wire [3:0]  comp_code_0,
    input  wire [3:0]  comp_code_1,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire        bitstream_pin_0,
    output wire        bitstream_pin_0_oe,
    output wire        bitstream_pin_1,
    output wire        bitstream_pin_1_oe,
    output wire [1:0]  bias_doubling
);

    // ****************************************************************
    // reset and configuration fields
    // ****************************************************************
    // hard reset pin acts like the bus reset on every piece of state
    wire       rst_all = reset | ~hard_reset_n;
    reg  [9:0] cfg_q;
    wire [1:0] stream_en   = cfg_q[`DMD_CFG_STREAM_LSB +: 2];
    wire [1:0] shutdown    = cfg_q[`DMD_CFG_SHDN_LSB +: 2];
    wire [1:0] ratio       = cfg_q[`DMD_CFG_RATIO_LSB +: 2];
    wire       wide        = cfg_q[`DMD_CFG_WIDE_BIT];
    wire       ready_latency_enable = cfg_q[`DMD_CFG_LAT_BIT];
    wire [7:0] comp_all    = {comp_code_1, comp_code_0};

    // bias doubling is only stored here; the analog side acts on it
    assign bias_doubling = cfg_q[`DMD_CFG_BIAS_LSB +: 2];

    // ****************************************************************
    // apb slave signals
    // ****************************************************************
    reg  [31:0] prdata_q;
    reg         pready_q;
    reg         pslverr_q;
    reg  [31:0] rd_mux;
    reg         addr_hit;
    wire        setup  = psel & ~penable;
    wire        access = psel & penable & pready_q;
    wire        wr_cfg = access & pwrite & (paddr == `DMD_OFF_CONFIG);
    wire [1:0]  rd_clr;

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign rd_clr[0] = access & ~pwrite & (paddr == `DMD_OFF_DATA0);
    assign rd_clr[1] = access & ~pwrite & (paddr == `DMD_OFF_DATA1);

    // ****************************************************************
    // modulator sample clock phase
    // ****************************************************************
    // four master clock ticks make one modulator sample period; phase
    // zero is the sample clock edge where a new quantizer code lands
    reg  [1:0] phase_q;
    wire       sample_tick = analog_master_clock_tick & (phase_q == 2'd0);

    // both channels down also stops the shared phase, so a restart
    // always lands the first code on a fresh sample edge
    always @(posedge sys_clk) begin
        if (rst_all || (&shutdown)) begin
            phase_q <= 2'd0;
        end else if (analog_master_clock_tick) begin
            phase_q <= phase_q + 2'd1;
        end
    end

    // ****************************************************************
    // per channel serializer, filter and output buffer
    // ****************************************************************
    wire [7:0]  snap_all;
    wire [47:0] data_all;
    wire [1:0]  ready_all;
    wire [1:0]  settled_all;
    wire [1:0]  pin_all;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            reg  [3:0]  snap_q;
            reg  [2:0]  shift_q;
            reg         bit_q;
            reg         first_q;
            reg  [23:0] data_q;
            reg         ready_q;
            wire [23:0] word;
            wire        word_valid;
            wire        word_settled;
            wire [3:0]  load_code;

            // a channel down or just restarted sends the zero pattern
            assign load_code = (shutdown[ch] || first_q) ?
                               `DMD_CODE_ZERO : comp_all[4*ch +: 4];

            // load on the sample edge, then shift once per master tick
            always @(posedge sys_clk) begin
                if (rst_all) begin
                    snap_q  <= `DMD_CODE_ZERO;
                    shift_q <= 3'b000;
                    bit_q   <= 1'b0;
                    first_q <= 1'b1;
                end else begin
                    if (shutdown[ch]) begin
                        first_q <= 1'b1;
                    end
                    if (sample_tick) begin
                        snap_q  <= load_code;
                        bit_q   <= load_code[3];
                        shift_q <= load_code[2:0];
                        first_q <= shutdown[ch];
                    end else if (analog_master_clock_tick) begin
                        bit_q   <= shift_q[2];
                        shift_q <= {shift_q[1:0], 1'b0};
                    end
                end
            end

            dmd_sinc3 u_sinc3 (
                .sys_clk     (sys_clk),
                .reset       (rst_all),
                .clear       (shutdown[ch]),
                .sample_tick (sample_tick),
                .code        (load_code),
                .ratio       (ratio),
                .wide        (wide),
                .word_q      (word),
                .valid_q     (word_valid),
                .settled_q   (word_settled)
            );

            // double buffer; the ready flag rises only for words the
            // host should see, and a new word beats a same-cycle read
            always @(posedge sys_clk) begin
                if (rst_all || shutdown[ch]) begin
                    data_q  <= 24'h000000;
                    ready_q <= 1'b0;
                end else begin
                    if (word_valid) begin
                        data_q <= word;
                    end
                    if (word_valid && (word_settled || !ready_latency_enable)) begin
                        ready_q <= 1'b1;
                    end else if (rd_clr[ch]) begin
                        ready_q <= 1'b0;
                    end
                end
            end

            assign snap_all[4*ch +: 4]   = snap_q;
            assign data_all[24*ch +: 24] = data_q;
            assign ready_all[ch]         = ready_q;
            assign settled_all[ch]       = word_settled;
            assign pin_all[ch]           = bit_q;
        end
    endgenerate

    // ****************************************************************
    // pins
    // ****************************************************************
    // enable follows the configuration flop directly, so the pin turns
    // on in the cycle after the write; hard reset clears it to float
    assign bitstream_pin_0    = pin_all[0];
    assign bitstream_pin_0_oe = stream_en[0];
    assign bitstream_pin_1    = pin_all[1];
    assign bitstream_pin_1_oe = stream_en[1];

    // ****************************************************************
    // register read decode
    // ****************************************************************
    always @* begin
        rd_mux   = 32'h00000000;
        addr_hit = 1'b1;
        case (paddr)
            `DMD_OFF_CONFIG:   rd_mux = {22'h000000, cfg_q};
            `DMD_OFF_SNAPSHOT: rd_mux = {24'h000000, snap_all};
            `DMD_OFF_DATA0:    rd_mux = {8'h00, data_all[23:0]};
            `DMD_OFF_DATA1:    rd_mux = {8'h00, data_all[47:24]};
            `DMD_OFF_STATUS:   rd_mux = {28'h0000000, settled_all, ready_all};
            default:           addr_hit = 1'b0;
        endcase
    end

    // ****************************************************************
    // apb handshake and configuration register
    // ****************************************************************
    // answer is prepared in the setup cycle so every bus output is a
    // flop; this costs nothing since pready is high in the first
    // access cycle
    always @(posedge sys_clk) begin
        if (rst_all) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pready_q  <= 1'b1;
            prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_q <= ~addr_hit;
        end else if (access) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // configuration changes land at the access edge of a write
    always @(posedge sys_clk) begin
        if (rst_all) begin
            cfg_q <= `DMD_CFG_RESET;
        end else if (wr_cfg) begin
            cfg_q <= pwdata[9:0];
        end
    end

endmodule

// ===== test/dmd_far_end.sv
`timescale 1ns/1ps
// ****************************************************************
// far-side receiver: regroups the serial bits into quantizer patterns
// ****************************************************************
module dmd_far_end (
    input  logic       sys_clk,
    input  logic       reset,
    input  logic       amc_tick,
    input  logic       pin,
    input  logic       pin_oe,
    output logic [3:0] pattern_q,
    output logic       pattern_valid_q
);
    logic [2:0] shift_q;
    logic [1:0] phase_q;
    logic       started_q;
    logic       bit_d;

    // a floating pin reads as the inverse of the last bit, never a stale copy
    assign bit_d = pin_oe ? pin : ~shift_q[0];

    // one bit per master tick; a group of four closes on every fourth tick
    always @(posedge sys_clk) begin
        pattern_valid_q <= 1'b0;
        if (reset) begin
            shift_q <= 3'h0;
            phase_q <= 2'h0;
            started_q <= 1'b0;
        end else if (amc_tick) begin
            shift_q <= {shift_q[1:0], bit_d};
            phase_q <= phase_q + 2'h1;
            started_q <= 1'b1;
            if (started_q && phase_q == 2'h0) begin
                pattern_q <= {shift_q, bit_d};
                pattern_valid_q <= 1'b1;
            end
        end
    end
endmodule

// ===== test/dmd_top_sva.sv
`timescale 1ns/1ps
module dmd_top_sva (
    input logic        sys_clk,
    input logic        reset,
    input logic        hard_reset_n,
    input logic        analog_master_clock_tick,
    input logic [3:0]  comp_code_0,
    input logic [3:0]  comp_code_1,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        bitstream_pin_0,
    input logic        bitstream_pin_0_oe,
    input logic        bitstream_pin_1,
    input logic        bitstream_pin_1_oe,
    input logic [1:0]  bias_doubling
);
    logic wide_q;
    wire  cfg_wr = psel && penable && pready && pwrite && paddr == 8'h00;
    wire  data_rd = pready && !pwrite && (paddr == 8'h08 || paddr == 8'h0c);

    // width bit shadow, so the data checks know the word size
    always @(posedge sys_clk) begin
        if (reset || !hard_reset_n) wide_q <= 1'b1;
        else if (cfg_wr) wide_q <= pwdata[6];
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence apb_setup_s;
        psel && !penable;
    endsequence
    sequence apb_done_s;
        psel && penable && pready;
    endsequence

    ready_answer_a: assert property (apb_setup_s |=> apb_done_s)
        else $error("no answer in first access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_cause_a: assert property (pready |-> $past(psel && !penable) && psel && penable)
        else $error("ready without a setup cycle");
    stream_oe_a: assert property (cfg_wr |=> bitstream_pin_0_oe == $past(pwdata[0])
        && bitstream_pin_1_oe == $past(pwdata[1])) else $error("pin enable not following");
    bias_copy_a: assert property (cfg_wr |=> bias_doubling == $past(pwdata[9:8]))
        else $error("bias bits not following");
    pin_tick_a: assert property ((hard_reset_n && $past(hard_reset_n)
        && !$stable({bitstream_pin_0, bitstream_pin_1})) |-> $past(analog_master_clock_tick))
        else $error("pin moved without a master tick");
    float_hard_a: assert property (!hard_reset_n |=> !bitstream_pin_0_oe
        && !bitstream_pin_1_oe) else $error("pins driven in hard reset");
    narrow_word_a: assert property (data_rd && !wide_q |-> prdata[31:16] == 16'h0)
        else $error("short word has upper bits set");
    wide_word_a: assert property (data_rd && wide_q |-> prdata[31:24] == 8'h0)
        else $error("long word has upper bits set");
    addr_refuse_a: assert property (pready && paddr > 8'h10 |-> pslverr && prdata == 32'h0)
        else $error("unmapped address not refused");
endmodule

bind dmd_top dmd_top_sva chk_u (
    .sys_clk(sys_clk), .reset(reset), .hard_reset_n(hard_reset_n),
    .analog_master_clock_tick(analog_master_clock_tick),
    .comp_code_0(comp_code_0), .comp_code_1(comp_code_1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bitstream_pin_0(bitstream_pin_0),
    .bitstream_pin_0_oe(bitstream_pin_0_oe), .bitstream_pin_1(bitstream_pin_1),
    .bitstream_pin_1_oe(bitstream_pin_1_oe), .bias_doubling(bias_doubling));

// ===== test/dmd_top_test.sv
`timescale 1ns/1ps
module dmd_top_test;
    logic        sys_clk, reset, hard_reset_n, amc_tick, psel, penable, pwrite;
    logic        tick_run, stream_chk, last_err;
    logic [3:0]  comp_code_0, comp_code_1, c0, c1;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd, cfg, seed_q;
    wire  [31:0] prdata;
    wire         pready, pslverr, pin0, oe0, pin1, oe1, pv0, pv1;
    wire  [1:0]  bias;
    wire  [3:0]  pat0, pat1;
    int          miscompares, num_checks, tick_cnt, pats, n, decimation_ratio_select;
    time         t0;
    logic [3:0]  exp_q[$];
    logic [3:0]  codes[5] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'h0};

    dmd_top dut_u (.sys_clk(sys_clk), .reset(reset), .hard_reset_n(hard_reset_n),
        .analog_master_clock_tick(amc_tick), .comp_code_0(comp_code_0),
        .comp_code_1(comp_code_1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bitstream_pin_0(pin0), .bitstream_pin_0_oe(oe0),
        .bitstream_pin_1(pin1), .bitstream_pin_1_oe(oe1), .bias_doubling(bias));
    dmd_far_end far0_u (.sys_clk(sys_clk), .reset(reset), .amc_tick(amc_tick), .pin(pin0),
        .pin_oe(oe0), .pattern_q(pat0), .pattern_valid_q(pv0));
    dmd_far_end far1_u (.sys_clk(sys_clk), .reset(reset), .amc_tick(amc_tick), .pin(pin1),
        .pin_oe(oe1), .pattern_q(pat1), .pattern_valid_q(pv1));

    // ****************************************************************
    // clock, master tick, helpers
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // master tick every second cycle, so four ticks make one sample period
    always @(posedge sys_clk) amc_tick <= tick_run && !amc_tick;

    function automatic logic [3:0] next_rand();
        seed_q = seed_q ^ (seed_q << 13);
        seed_q = seed_q ^ (seed_q >> 17);
        seed_q = seed_q ^ (seed_q << 5);
        return seed_q[3:0];
    endfunction

    // settled word for a constant code: full scale is two levels
    function automatic logic [31:0] exp_word(input logic [3:0] c, input logic w);
        int v;
        case (c)
            4'hf: v = 2;
            4'h7: v = 1;
            4'h1: v = -1;
            4'h0: v = -2;
            default: v = 0;
        endcase
        v = v * 4194304;
        if (v > 8388607) v = 8388607;
        if (w) return {8'h0, v[23:0]};
        v = (v + 128) >>> 8;
        if (v > 32767) v = 32767;
        return {16'h0, v[15:0]};
    endfunction

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_pat(input logic [3:0] got, input logic [3:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // request held until the edge where ready is seen; data taken there
    task automatic apb(input [7:0] a, input w, input [31:0] d, output [31:0] r);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) miscompares++;
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task stop_test;
        if (miscompares == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ****************************************************************
    // bitstream scoreboard: random codes, one new code per sample edge
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (amc_tick) begin
            tick_cnt <= tick_cnt + 1;
            if (stream_chk && tick_cnt % 4 == 0) begin
                exp_q.push_back(tick_cnt == 0 ? 4'h3 : comp_code_0);
                comp_code_0 <= next_rand();
            end
        end
        if (stream_chk && pv0) begin
            chk_pat(pat0, exp_q.pop_front());
            chk_pat(pat1, 4'h3);
            pats <= pats + 1;
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {psel, penable, pwrite, amc_tick, tick_run, stream_chk} = 6'h0;
        {paddr, pwdata} = 40'h0;
        {comp_code_0, comp_code_1} = 8'hf3;
        {reset, hard_reset_n} = 2'b11;
        {tick_cnt, pats, miscompares, num_checks} = 128'h0;
        seed_q = 32'd53;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        // stream both, channel 1 down; bias set before ticks run fast
        apb(8'h00, 1'b1, 32'h3cb, rd);
        @(posedge sys_clk);
        chk_val({30'h0, oe1, oe0}, 32'h3);
        chk_val({30'h0, bias}, 32'h3);
        stream_chk <= 1'b1;
        tick_run <= 1'b1;
        for (n = 0; n < 2000 && pats < 20; n++) @(posedge sys_clk);
        chk_val(pats, 20);
        stream_chk <= 1'b0;
        apb(8'h14, 1'b0, 32'h0, rd);
        chk_val({rd[31:1], last_err}, 32'h1);
        // every ratio at both widths, every code on channel 0
        for (int i = 0; i < 8; i++) begin
            c0 = codes[i % 5];
            c1 = codes[next_rand() % 5];
            decimation_ratio_select = 32 << i[1:0];
            cfg = {22'h0, 2'b11, 1'b1, i[2], i[1:0], 2'b11, 2'b11};
            apb(8'h00, 1'b1, cfg, rd);
            // the zero code needs one master tick after the shared phase stops
            repeat (4) @(posedge sys_clk);
            apb(8'h04, 1'b0, 32'h0, rd);
            chk_val(rd, 32'h33);
            comp_code_0 <= c0;
            comp_code_1 <= c1;
            t0 = $time;
            apb(8'h00, 1'b1, cfg & 32'hfffffff3, rd);
            n = 0;
            do begin
                apb(8'h10, 1'b0, 32'h0, rd);
                n++;
            end while (rd[1:0] !== 2'b11 && n < 3000);
            chk_val({28'h0, rd[3:0]}, 32'hf);
            chk_val(($time - t0) >= 200 * decimation_ratio_select, 1);
            // the forced zero first sample still sits in the third word's tail
            repeat (8 * decimation_ratio_select) @(posedge sys_clk);
            apb(8'h08, 1'b0, 32'h0, rd);
            chk_val(rd, exp_word(c0, i[2]));
            apb(8'h0c, 1'b0, 32'h0, rd);
            chk_val(rd, exp_word(c1, i[2]));
            apb(8'h04, 1'b0, 32'h0, rd);
            chk_val(rd, {24'h0, c1, c0});
        end
        hard_reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk_val({30'h0, oe1, oe0}, 32'h0);
        hard_reset_n <= 1'b1;
        apb(8'h08, 1'b0, 32'h0, rd);
        chk_val(rd, 32'h0);
        apb(8'h10, 1'b0, 32'h0, rd);
        chk_val(rd, 32'h0);
        apb(8'h00, 1'b0, 32'h0, rd);
        chk_val(rd, 32'h050);
        stop_test;
    end

    // hang guard, well beyond the slowest ratio's three words
    initial begin
        repeat (90000) @(posedge sys_clk);
        miscompares++;
        stop_test;
    end
endmodule
